// >>> pkg/sysref_pkg.sv
`default_nettype none
package sysref_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Bus geometry and channel count
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int NUM_CHANNELS = 4;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] CONTROL_OFFSET    = 8'h00;
  localparam logic [7:0] DIVIDER_OFFSET    = 8'h04;
  localparam logic [7:0] OUTPUT_CFG_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET     = 8'h0C;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions and widths
  localparam int CONT_BIT       = 0;
  localparam int SOURCE_BIT     = 1;
  localparam int RELEASE_BIT    = 2;
  localparam int STOP_BIT       = 3;
  localparam int COUNT_LSB      = 8;
  localparam int COUNT_W        = 8;
  localparam int RATE_LSB       = 0;
  localparam int RATE_W         = 13;
  localparam int SYNC_LSB       = 16;
  localparam int SYNC_W         = 7;
  localparam int MASK_LSB       = 0;
  localparam int BIAS_LSB       = 8;
  localparam int BIAS_TYPE_BIT  = 16;
  localparam int STATE_LSB      = 0;
  localparam int REMAIN_LSB     = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and divider limits
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h01;
  localparam logic [RATE_W-1:0]  RATE_RESET  = 13'h0180;
  localparam logic [RATE_W-1:0]  RATE_MIN    = 13'h0040;
  localparam logic [RATE_W-1:0]  RATE_MAX    = 13'h1400;
  localparam logic [SYNC_W-1:0]  SYNC_RESET  = 7'h01;

  typedef enum logic [1:0] {GEN_IDLE, GEN_ARMED, GEN_ALIGN, GEN_RUN} gen_state_t;

endpackage : sysref_pkg
`default_nettype wire

// >>> pkg/pulse_timing_if.sv
`default_nettype none
interface pulse_timing_if;
  logic                           run;
  logic [sysref_pkg::RATE_W-1:0]  rate;
  logic [sysref_pkg::SYNC_W-1:0]  sync_div;
  logic                           sync_tick;
  logic                           period_end;
  logic                           high_phase;

  modport control (output run, output rate, output sync_div,
                   input sync_tick, input period_end, input high_phase);
  modport timer   (input run, input rate, input sync_div,
                   output sync_tick, output period_end, output high_phase);
endinterface : pulse_timing_if
`default_nettype wire

// >>> verilog/trigger_edge_detect.sv
`default_nettype none
module trigger_edge_detect (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Trigger
  input  wire logic trigger_in,
  output logic      trigger_rise
);
  logic sync_first;
  logic sync_second;
  logic sync_prev;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      sync_prev   <= 1'b0;
    end else begin
      sync_first  <= trigger_in;
      sync_second <= sync_first;
      sync_prev   <= sync_second;
    end
  end

  // The second stage and its one-cycle delayed copy feed the edge logic
  assign trigger_rise = sync_second & ~sync_prev;
endmodule : trigger_edge_detect
`default_nettype wire

// >>> verilog/rate_timer.sv
`default_nettype none
module rate_timer (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Timing link to the controller
  pulse_timing_if.timer timing
);
  logic [sysref_pkg::RATE_W-1:0] rate_cnt;
  logic [sysref_pkg::SYNC_W-1:0] sync_cnt;
  logic [sysref_pkg::SYNC_W-1:0] sync_last;
  logic [sysref_pkg::RATE_W-1:0] rate_last;

  // A zero coincidence divider behaves as divide by one
  assign sync_last = (timing.sync_div == '0) ? '0 : timing.sync_div - 7'h01;
  assign rate_last = timing.rate - 13'h0001;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_cnt <= '0;
    end else if (sync_cnt >= sync_last) begin
      sync_cnt <= '0;
    end else begin
      sync_cnt <= sync_cnt + 7'h01;
    end
  end

  // Period counter restarts with every run so the first edge is on the tick
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rate_cnt <= '0;
    end else if (!timing.run || rate_cnt == rate_last) begin
      rate_cnt <= '0;
    end else begin
      rate_cnt <= rate_cnt + 13'h0001;
    end
  end

  assign timing.sync_tick  = (sync_cnt == '0);
  assign timing.period_end = timing.run && (rate_cnt == rate_last);
  assign timing.high_phase = timing.run && (rate_cnt < (timing.rate >> 1));
endmodule : rate_timer
`default_nettype wire

// >>> verilog/sysref_pulse_generator.sv
// Implementation choices: the register offsets and the APB interface to the registers.
`default_nettype none
module sysref_pulse_generator #(
  parameter int NUM_CH = sysref_pkg::NUM_CHANNELS
) (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            resetn,
  // APB slave
  input  wire logic [sysref_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [sysref_pkg::DATA_W-1:0]   pwdata,
  output logic      [sysref_pkg::DATA_W-1:0]   prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Trigger
  input  wire logic                            external_trigger_input,
  // Reference outputs
  output logic      [NUM_CH-1:0]               reference_pulse_output,
  output logic      [NUM_CH-1:0]               reference_output_enable,
  output logic      [NUM_CH-1:0]               reference_crosspoint_bias,
  output logic                                 event_active
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic                                continuous_select;
  logic                                source_select;
  logic [sysref_pkg::COUNT_W-1:0]      pulse_count_setting;
  logic [sysref_pkg::RATE_W-1:0]       rate_divider;
  logic [sysref_pkg::SYNC_W-1:0]       sync_divider;
  logic [NUM_CH-1:0]                   channel_mask;
  logic [NUM_CH-1:0]                   idle_bias_enable;
  logic                                bias_type;
  logic [sysref_pkg::COUNT_W-1:0]      remaining;
  logic                                stop_request;
  logic                                pulse_level;
  sysref_pkg::gen_state_t              state;
  sysref_pkg::gen_state_t              next_state;

  pulse_timing_if timing ();

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire setup_phase   = psel && !penable;
  wire access_write  = psel && penable && pwrite;
  wire hit_control   = (paddr == sysref_pkg::CONTROL_OFFSET);
  wire hit_divider   = (paddr == sysref_pkg::DIVIDER_OFFSET);
  wire hit_output    = (paddr == sysref_pkg::OUTPUT_CFG_OFFSET);
  wire hit_status    = (paddr == sysref_pkg::STATUS_OFFSET);
  wire addr_mapped   = hit_control || hit_divider || hit_output || hit_status;
  wire write_control = access_write && hit_control;
  wire write_divider = access_write && hit_divider;
  wire write_output  = access_write && hit_output;
  wire release_cmd   = write_control && pwdata[sysref_pkg::RELEASE_BIT];
  wire stop_cmd      = write_control && pwdata[sysref_pkg::STOP_BIT];

  // Zero-wait slave; unmapped addresses answer with an error and read zero
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !addr_mapped;

  wire [sysref_pkg::DATA_W-1:0] read_control =
    {16'h0000, pulse_count_setting, 6'h00, source_select, continuous_select};
  wire [sysref_pkg::DATA_W-1:0] read_divider =
    {9'h000, sync_divider, 3'h0, rate_divider};
  wire [sysref_pkg::DATA_W-1:0] read_output =
    {15'h0000, bias_type, 8'(idle_bias_enable), 8'(channel_mask)};
  wire [sysref_pkg::DATA_W-1:0] read_status =
    {16'h0000, remaining, 6'h00, 2'(state)};
  wire [sysref_pkg::DATA_W-1:0] read_mux =
    hit_control ? read_control :
    hit_divider ? read_divider :
    hit_output  ? read_output  :
    hit_status  ? read_status  : 32'h0000_0000;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata <= read_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  wire [sysref_pkg::RATE_W-1:0] rate_written =
    pwdata[sysref_pkg::RATE_LSB +: sysref_pkg::RATE_W];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      continuous_select   <= 1'b0;
      source_select       <= 1'b0;
      pulse_count_setting <= sysref_pkg::COUNT_RESET;
    end else if (write_control) begin
      continuous_select   <= pwdata[sysref_pkg::CONT_BIT];
      source_select       <= pwdata[sysref_pkg::SOURCE_BIT];
      pulse_count_setting <= pwdata[sysref_pkg::COUNT_LSB +: sysref_pkg::COUNT_W];
    end
  end

  // Out-of-range rate divider ratios are held to the supported span; the sync divider is stored as written
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rate_divider <= sysref_pkg::RATE_RESET;
      sync_divider <= sysref_pkg::SYNC_RESET;
    end else if (write_divider) begin
      rate_divider <= (rate_written < sysref_pkg::RATE_MIN) ? sysref_pkg::RATE_MIN :
                      (rate_written > sysref_pkg::RATE_MAX) ? sysref_pkg::RATE_MAX :
                      rate_written;
      sync_divider <= pwdata[sysref_pkg::SYNC_LSB +: sysref_pkg::SYNC_W];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      channel_mask     <= '0;
      idle_bias_enable <= '0;
      bias_type        <= 1'b0;
    end else if (write_output) begin
      channel_mask     <= pwdata[sysref_pkg::MASK_LSB +: NUM_CH];
      idle_bias_enable <= pwdata[sysref_pkg::BIAS_LSB +: NUM_CH];
      bias_type        <= pwdata[sysref_pkg::BIAS_TYPE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trigger and timing
  logic trigger_rise;

  trigger_edge_detect trigger_sync (
    .clock        (clock),
    .resetn       (resetn),
    .trigger_in   (external_trigger_input),
    .trigger_rise (trigger_rise)
  );

  rate_timer timer (
    .clock  (clock),
    .resetn (resetn),
    .timing (timing.timer)
  );

  // Same timer path whichever source starts the event
  assign timing.run      = (state == sysref_pkg::GEN_RUN);
  assign timing.rate     = rate_divider;
  assign timing.sync_div = sync_divider;

  //////////////////////////////////////////////////////////////////////////////
  // Event sequencer
  wire idle_release  = release_cmd && (state == sysref_pkg::GEN_IDLE);
  wire last_pulse    = !continuous_select && (remaining <= 8'h01);
  wire burst_done    = timing.period_end && (last_pulse || stop_request);
  // Release takes source and count from its own write word, not the old register
  wire                           source_written = pwdata[sysref_pkg::SOURCE_BIT];
  wire [sysref_pkg::COUNT_W-1:0] count_written  =
    pwdata[sysref_pkg::COUNT_LSB +: sysref_pkg::COUNT_W];
  // A zero count still produces one pulse
  wire [sysref_pkg::COUNT_W-1:0] count_loaded =
    (count_written == '0) ? 8'h01 : count_written;

  always_comb begin
    next_state = state;
    case (state)
      sysref_pkg::GEN_IDLE: begin
        if (idle_release) begin
          next_state = source_written ? sysref_pkg::GEN_ARMED
                                     : sysref_pkg::GEN_ALIGN;
        end
      end
      sysref_pkg::GEN_ARMED: begin
        if (stop_cmd) begin
          next_state = sysref_pkg::GEN_IDLE;
        end else if (trigger_rise) begin
          next_state = sysref_pkg::GEN_ALIGN;
        end
      end
      sysref_pkg::GEN_ALIGN: begin
        if (timing.sync_tick) begin
          next_state = sysref_pkg::GEN_RUN;
        end
      end
      sysref_pkg::GEN_RUN: begin
        // Triggers are not looked at until the event is over
        if (burst_done) begin
          next_state = sysref_pkg::GEN_IDLE;
        end
      end
      default: next_state = sysref_pkg::GEN_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= sysref_pkg::GEN_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Count is captured at release so later writes do not disturb the burst
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      remaining <= '0;
    end else if (idle_release) begin
      remaining <= count_loaded;
    end else if (timing.period_end && !continuous_select && remaining != '0) begin
      remaining <= remaining - 8'h01;
    end
  end

  // Continuous output ends only on a stop command, at a period boundary
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stop_request <= 1'b0;
    end else if (idle_release) begin
      stop_request <= 1'b0;
    end else if (stop_cmd && state != sysref_pkg::GEN_IDLE) begin
      stop_request <= 1'b1;
    end else if (state == sysref_pkg::GEN_IDLE) begin
      stop_request <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pulse_level  <= 1'b0;
      event_active <= 1'b0;
    end else begin
      pulse_level  <= timing.high_phase;
      event_active <= (next_state == sysref_pkg::GEN_ALIGN) ||
                      (next_state == sysref_pkg::GEN_RUN);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel output stage
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_channel
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        reference_pulse_output[ch]    <= 1'b0;
        reference_output_enable[ch]   <= 1'b0;
        reference_crosspoint_bias[ch] <= 1'b0;
      end else begin
        reference_pulse_output[ch]    <= channel_mask[ch] && pulse_level;
        reference_output_enable[ch]   <= channel_mask[ch] && event_active;
        reference_crosspoint_bias[ch] <= channel_mask[ch] && !event_active &&
                                         bias_type && idle_bias_enable[ch];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic [sysref_pkg::COUNT_W:0]  rises_seen;
  logic [sysref_pkg::COUNT_W-1:0] count_taken;
  logic [sysref_pkg::RATE_W:0]   since_rise;
  logic                          rise_seen_once;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rises_seen     <= '0;
      count_taken    <= '0;
      since_rise     <= '0;
      rise_seen_once <= 1'b0;
    end else begin
      if (idle_release) begin
        rises_seen     <= '0;
        count_taken    <= count_loaded;
        rise_seen_once <= 1'b0;
      end else if (timing.high_phase && !pulse_level) begin
        rises_seen     <= rises_seen + 9'h001;
        rise_seen_once <= 1'b1;
      end
      since_rise <= (timing.high_phase && !pulse_level) ? 14'h0001 : since_rise + 14'h0001;
    end
  end

  sequence release_internal_s;
    idle_release && !source_written;
  endsequence

  sequence align_then_run_s;
    (state == sysref_pkg::GEN_ALIGN) ##1 (state == sysref_pkg::GEN_RUN);
  endsequence

  chk_internal_release: assert property (release_internal_s |=> state == sysref_pkg::GEN_ALIGN)
    else $error("internal release did not start alignment");
  chk_count_loaded: assert property (idle_release |=> remaining == $past(count_loaded))
    else $error("pulse count not loaded on release");
  chk_sync_gates_run: assert property (align_then_run_s |-> $past(timing.sync_tick))
    else $error("run began without coincidence tick");
  chk_burst_length: assert property (
      $fell(state == sysref_pkg::GEN_RUN) && !$past(continuous_select) && !$past(stop_request)
      |-> rises_seen == 9'(count_taken))
    else $error("burst pulse count wrong");
  chk_rate_period: assert property (
      timing.high_phase && !pulse_level && rise_seen_once && timing.run
      |-> since_rise == 14'(rate_divider))
    else $error("pulse period differs from divider");
  chk_trigger_ignored: assert property (
      state == sysref_pkg::GEN_RUN && trigger_rise |=> state != sysref_pkg::GEN_ARMED)
    else $error("trigger accepted during event");
  chk_armed_waits: assert property (
      state == sysref_pkg::GEN_ARMED && !trigger_rise && !stop_cmd
      |=> state == sysref_pkg::GEN_ARMED)
    else $error("armed generator left without trigger");
  chk_trigger_starts: assert property (
      state == sysref_pkg::GEN_ARMED && trigger_rise && !stop_cmd
      |=> state == sysref_pkg::GEN_ALIGN ##[1:127] state == sysref_pkg::GEN_RUN)
    else $error("trigger did not release pulses");
  chk_idle_quiet: assert property (
      state == sysref_pkg::GEN_IDLE [*3] |-> reference_pulse_output == '0)
    else $error("output toggling while idle");
  chk_power_follows: assert property (
      state == sysref_pkg::GEN_RUN |=> reference_output_enable == channel_mask)
    else $error("outputs not powered during event");
  chk_continuous_hold: assert property (
      continuous_select && timing.period_end && !idle_release |=> $stable(remaining))
    else $error("count moved in continuous mode");

endmodule : sysref_pulse_generator
`default_nettype wire

// >>> verif/sysref_receiver.sv
`default_nettype none
module sysref_receiver (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Reference line and bookkeeping
  input  wire logic       ref_in,
  input  wire logic       clear,
  output logic      [7:0] pulses,
  output logic      [7:0] high_len
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       ref_prev;
  logic [7:0] run_len;

  // Counts rising edges and keeps the width of the last finished pulse
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_prev <= 1'b0;
      run_len  <= 8'h00;
      pulses   <= 8'h00;
      high_len <= 8'h00;
    end else if (clear) begin
      pulses   <= 8'h00;
      high_len <= 8'h00;
    end else begin
      ref_prev <= ref_in;
      if (ref_in && !ref_prev) begin
        pulses  <= pulses + 8'h01;
        run_len <= 8'h01;
      end else if (ref_in) begin
        run_len <= run_len + 8'h01;
      end else if (ref_prev) begin
        high_len <= run_len;
      end
    end
  end
endmodule : sysref_receiver
`default_nettype wire

// >>> verif/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int CEILING = 30000;
  logic        clock   = 1'b0;
  logic        resetn  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        trig    = 1'b0;
  logic        rx_clear = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  ref_out;
  logic [3:0]  ref_en;
  logic [3:0]  ref_bias;
  logic        event_active;
  logic [7:0]  pulses;
  logic [7:0]  high_len;
  logic [31:0] rdata_seen;
  logic        err_seen;
  int          fail_count  = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  sysref_pulse_generator dut (.clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_trigger_input(trig), .reference_pulse_output(ref_out),
    .reference_output_enable(ref_en), .reference_crosspoint_bias(ref_bias),
    .event_active(event_active));
  sysref_receiver rx (.clock(clock), .resetn(resetn), .ref_in(ref_out[0]), .clear(rx_clear),
    .pulses(pulses), .high_len(high_len));

  always #20 clock = ~clock;

  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // A hung handshake or event ends the run through the same report
  always @(posedge clock) begin
    cycles++;
    if (cycles == CEILING) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata_seen = prdata;
    err_seen   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clock);
    while (event_active !== 1'b0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    // A burst that never ends is a mismatch, not a silent pass
    if (n >= 20000) begin
      fail_count++;
    end
    repeat (4) @(posedge clock);
  endtask : wait_idle

  task automatic clear_rx();
    @(posedge clock);
    rx_clear <= 1'b1;
    @(posedge clock);
    rx_clear <= 1'b0;
  endtask : clear_rx

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, sysref_pkg::CONTROL_OFFSET, 32'h0000_0000);
    check("control reset", 32'h0000_0100, rdata_seen);
    apb(1'b0, sysref_pkg::DIVIDER_OFFSET, 32'h0000_0000);
    check("divider reset", 32'h0001_0180, rdata_seen);
    apb(1'b1, sysref_pkg::DIVIDER_OFFSET, 32'h0001_1FFF);
    apb(1'b0, sysref_pkg::DIVIDER_OFFSET, 32'h0000_0000);
    check("divider top", 32'h0001_1400, rdata_seen);
    apb(1'b1, sysref_pkg::DIVIDER_OFFSET, 32'h0001_0010);
    apb(1'b0, sysref_pkg::DIVIDER_OFFSET, 32'h0000_0000);
    check("divider floor", 32'h0001_0040, rdata_seen);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped error", 32'h1, 32'(err_seen));
    check("idle outputs", 32'h0, 32'({event_active, ref_en, ref_out}));
  endtask : t_reset

  task automatic t_counted(input logic [7:0] count);
    int n;
    n = 0;
    apb(1'b1, sysref_pkg::OUTPUT_CFG_OFFSET, 32'h0000_000F);
    clear_rx();
    apb(1'b1, sysref_pkg::CONTROL_OFFSET, {16'h0000, count, 8'h04});
    while (ref_out[0] !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    check("all channels pulse", 32'h0F, 32'(ref_out));
    check("enables on", 32'h0F, 32'(ref_en));
    apb(1'b0, sysref_pkg::STATUS_OFFSET, 32'h0000_0000);
    check("state run", 32'h3, rdata_seen & 32'h3);
    wait_idle();
    check("pulse count", 32'(count), 32'(pulses));
    check("pulse width", 32'd32, 32'(high_len));
    check("after burst", 32'h0, 32'({ref_en, ref_out}));
  endtask : t_counted

  task automatic t_continuous();
    apb(1'b1, sysref_pkg::OUTPUT_CFG_OFFSET, 32'h0001_030F);
    repeat (3) @(posedge clock);
    check("idle crosspoint", 32'h3, 32'(ref_bias));
    clear_rx();
    apb(1'b1, sysref_pkg::CONTROL_OFFSET, 32'h0000_0205);
    repeat (384) @(posedge clock);
    check("bias off in event", 32'h0, 32'(ref_bias));
    check("still running", 32'h1, 32'(event_active));
    check("free running", 32'h1, 32'(pulses > 8'h04));
    apb(1'b1, sysref_pkg::CONTROL_OFFSET, 32'h0000_0209);
    wait_idle();
    check("crosspoint again", 32'h3, 32'(ref_bias));
    apb(1'b1, sysref_pkg::OUTPUT_CFG_OFFSET, 32'h0000_030F);
    repeat (3) @(posedge clock);
    check("type zero low", 32'h0, 32'({ref_bias, ref_out}));
  endtask : t_continuous

  task automatic t_external();
    clear_rx();
    // Divide-three clocks: coincidence every 3, rate 384
    apb(1'b1, sysref_pkg::DIVIDER_OFFSET, 32'h0003_0180);
    apb(1'b1, sysref_pkg::CONTROL_OFFSET, 32'h0000_0206);
    repeat (20) @(posedge clock);
    check("armed waits", 32'h0, 32'(event_active));
    apb(1'b0, sysref_pkg::STATUS_OFFSET, 32'h0000_0000);
    check("state armed", 32'h1, rdata_seen & 32'h3);
    trig <= 1'b1;
    repeat (10) @(posedge clock);
    trig <= 1'b0;
    check("trigger starts", 32'h1, 32'(event_active));
    repeat (40) @(posedge clock);
    trig <= 1'b1;
    repeat (5) @(posedge clock);
    trig <= 1'b0;
    wait_idle();
    check("external count", 32'h2, 32'(pulses));
    check("external width", 32'd192, 32'(high_len));
    trig <= 1'b1;
    repeat (20) @(posedge clock);
    trig <= 1'b0;
    check("unarmed ignores", 32'h0, 32'(event_active));
    apb(1'b1, sysref_pkg::CONTROL_OFFSET, 32'h0000_0206);
    apb(1'b1, sysref_pkg::CONTROL_OFFSET, 32'h0000_020A);
    apb(1'b0, sysref_pkg::STATUS_OFFSET, 32'h0000_0000);
    check("stop cancels arm", 32'h0, rdata_seen & 32'h3);
  endtask : t_external

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    // Rate and alignment set up before any release
    apb(1'b1, sysref_pkg::DIVIDER_OFFSET, 32'h0001_0040);
    t_counted(8'h01);
    t_counted(8'hFF);
    t_continuous();
    t_external();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
